// ==== rtl/accs_cfg.svh ====
`ifndef ACCS_CFG_SVH
`define ACCS_CFG_SVH
// Register indices; byte address is four times the index
`define ACCS_IDX_OSCFG 8'h65
`define ACCS_IDX_AVG 8'h68
`define ACCS_IDX_STAT 8'h6a
`define ACCS_IDX_CALCFG0 8'h62
`define ACCS_IDX_IRQ_STAT 8'h70
`define ACCS_IDX_IRQ_MASK 8'h71
`define ACCS_RST_OSCFG 8'h01
`define ACCS_RST_AVG 8'h61
`define ACCS_RST_CALCFG0 8'h01
`define ACCS_BIT_OFFREF 2
`define ACCS_OSAVG_HI 6
`define ACCS_OSAVG_LO 4
`define ACCS_LINAVG_HI 2
`define ACCS_LINAVG_LO 0
`define ACCS_BIT_FGRUN 0
`define ACCS_BIT_BGEN 1
`define ACCS_BIT_DONE 0
`define ACCS_BIT_HALT 1
`define ACCS_CODE_HI 4
`define ACCS_CODE_LO 2
`define ACCS_STAT_RSVD_HI 7
`define ACCS_STAT_RSVD_LO 5
`define ACCS_IRQ_W 2
`endif

// ==== rtl/accs_pkg.sv ====
package accs_pkg;
    typedef logic [7:0] accs_byte_t;
    typedef logic [2:0] accs_code_t;
endpackage

// ==== rtl/accs_top.sv ====
// Overview of operation
// - Reference select zero calibrates toward mid-code
// - Reference select one aligns to spare converter
// - Offset averaging field bits 6:4, reset 6
// - Linearity averaging field bits 2:0, reset 1
// - Halted flag set when background stops
// - Halted flag clears when calibration resumes
// - Without background, halt set on foreground done
// - Foreground complete flag held high when done
// - Status read-only, code bits 4:2, reserved zero
// - Background enable bit turns background on
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
`include "accs_cfg.svh"
module accs_top
    import accs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic fg_complete_i,
    input wire logic bg_halted_i,
    input wire logic bg_running_i,
    input wire logic [2:0] cal_code_i,
    output logic offset_reference_select_o,
    output logic [2:0] offset_averaging_level_o,
    output logic [2:0] linearity_averaging_level_o,
    output logic background_calibration_enable_o,
    output logic foreground_run_o,
    output logic irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Engine status inputs come from another domain, so two flops each

logic [5:0] sync1_r;
logic [5:0] sync2_r;
logic [5:0] sync_nxt;

always_comb
begin
    sync_nxt = {cal_code_i, bg_running_i, bg_halted_i, fg_complete_i};
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        sync1_r <= '0;
        sync2_r <= '0;
    end
    else
    begin
        sync1_r <= sync_nxt;
        sync2_r <= sync1_r;
    end
end

logic s_done;
logic s_halt;
logic s_run;
accs_code_t s_code;
assign s_done = sync2_r[0];
assign s_halt = sync2_r[1];
assign s_run = sync2_r[2];
assign s_code = sync2_r[5:3];

// Code bits may settle apart; take the code once it reads the same twice
accs_code_t code_prev_r, code_prev_nxt;
accs_code_t code_ok_r, code_ok_nxt;

always_comb
begin
    code_prev_nxt = s_code;
    code_ok_nxt = code_ok_r;
    if (s_code == code_prev_r)
        code_ok_nxt = s_code;
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        code_prev_r <= '0;
        code_ok_r <= '0;
    end
    else
    begin
        code_prev_r <= code_prev_nxt;
        code_ok_r <= code_ok_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bus decode: one word per index, low byte lane carries the data

logic req;
logic wr0;
logic [7:0] idx;
assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
assign idx = wb_adr_i[9:2];
assign wr0 = req && wb_we_i && wb_sel_i[0];

logic hit;
always_comb
begin
    if (idx == `ACCS_IDX_OSCFG)
        hit = 1'b1;
    else if (idx == `ACCS_IDX_AVG)
        hit = 1'b1;
    else if (idx == `ACCS_IDX_STAT)
        hit = 1'b1;
    else if (idx == `ACCS_IDX_CALCFG0)
        hit = 1'b1;
    else if (idx == `ACCS_IDX_IRQ_STAT)
        hit = 1'b1;
    else if (idx == `ACCS_IDX_IRQ_MASK)
        hit = 1'b1;
    else
        hit = 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Configuration and status state

accs_byte_t oscfg_r, oscfg_nxt;
accs_byte_t avg_r, avg_nxt;
accs_byte_t cfg0_r, cfg0_nxt;
accs_byte_t stat_r, stat_nxt;
logic [`ACCS_IRQ_W-1:0] ist_r, ist_nxt;
logic [`ACCS_IRQ_W-1:0] imsk_r, imsk_nxt;
logic done_d_r, done_d_nxt;
logic halt_d_r, halt_d_nxt;
logic halted;
logic [`ACCS_IRQ_W-1:0] ev;

always_comb
begin
    oscfg_nxt = oscfg_r;
    avg_nxt = avg_r;
    cfg0_nxt = cfg0_r;
    imsk_nxt = imsk_r;
    if (wr0 && idx == `ACCS_IDX_OSCFG)
        oscfg_nxt = wb_dat_i[7:0];
    else if (wr0 && idx == `ACCS_IDX_AVG)
        avg_nxt = wb_dat_i[7:0];
    else if (wr0 && idx == `ACCS_IDX_CALCFG0)
        cfg0_nxt = wb_dat_i[7:0];
    else if (wr0 && idx == `ACCS_IDX_IRQ_MASK)
        imsk_nxt = wb_dat_i[`ACCS_IRQ_W-1:0];
end

// Halt flag: engine halt while not running when background on, else mirrors foreground done
always_comb
begin
    if (cfg0_r[`ACCS_BIT_BGEN])
        halted = s_halt && !s_run;
    else
        halted = s_done;
end

// Status never takes bus data, only engine state
always_comb
begin
    stat_nxt = 8'h00;
    stat_nxt[`ACCS_BIT_DONE] = s_done;
    stat_nxt[`ACCS_BIT_HALT] = halted;
    stat_nxt[`ACCS_CODE_HI:`ACCS_CODE_LO] = code_ok_r;
    done_d_nxt = stat_r[`ACCS_BIT_DONE];
    halt_d_nxt = stat_r[`ACCS_BIT_HALT];
end

// Rising edges of done and halt are the events; set beats clear
always_comb
begin
    ev[0] = stat_r[`ACCS_BIT_DONE] && !done_d_r;
    ev[1] = stat_r[`ACCS_BIT_HALT] && !halt_d_r;
    ist_nxt = ist_r;
    if (wr0 && idx == `ACCS_IDX_IRQ_STAT)
        ist_nxt = ist_r & ~wb_dat_i[`ACCS_IRQ_W-1:0];
    ist_nxt = ist_nxt | ev;
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        oscfg_r <= `ACCS_RST_OSCFG;
        avg_r <= `ACCS_RST_AVG;
        cfg0_r <= `ACCS_RST_CALCFG0;
        stat_r <= 8'h00;
        ist_r <= '0;
        imsk_r <= '0;
        done_d_r <= 1'b0;
        halt_d_r <= 1'b0;
    end
    else
    begin
        oscfg_r <= oscfg_nxt;
        avg_r <= avg_nxt;
        cfg0_r <= cfg0_nxt;
        stat_r <= stat_nxt;
        ist_r <= ist_nxt;
        imsk_r <= imsk_nxt;
        done_d_r <= done_d_nxt;
        halt_d_r <= halt_d_nxt;
    end
end

// Zero picks mid-code, one picks the spare converter as reference
assign offset_reference_select_o = oscfg_r[`ACCS_BIT_OFFREF];
assign offset_averaging_level_o =
    avg_r[`ACCS_OSAVG_HI:`ACCS_OSAVG_LO];
assign linearity_averaging_level_o =
    avg_r[`ACCS_LINAVG_HI:`ACCS_LINAVG_LO];
assign background_calibration_enable_o = cfg0_r[`ACCS_BIT_BGEN];
assign foreground_run_o = cfg0_r[`ACCS_BIT_FGRUN];
assign irq_o = |(ist_r & imsk_r);

////////////////////////////////////////////////////////////////////////////////
// Bus answer, registered: ack or err one cycle after the request

logic ack_r, ack_nxt;
logic err_r, err_nxt;
logic [31:0] rd_r, rd_nxt;

always_comb
begin
    ack_nxt = req && hit;
    err_nxt = req && !hit;
    rd_nxt = rd_r;
    if (req && !wb_we_i)
    begin
        rd_nxt = 32'h0000_0000;
        if (idx == `ACCS_IDX_OSCFG)
            rd_nxt[7:0] = oscfg_r;
        else if (idx == `ACCS_IDX_AVG)
            rd_nxt[7:0] = avg_r;
        else if (idx == `ACCS_IDX_STAT)
            rd_nxt[7:0] = stat_r;
        else if (idx == `ACCS_IDX_CALCFG0)
            rd_nxt[7:0] = cfg0_r;
        else if (idx == `ACCS_IDX_IRQ_STAT)
            rd_nxt[`ACCS_IRQ_W-1:0] = ist_r;
        else if (idx == `ACCS_IDX_IRQ_MASK)
            rd_nxt[`ACCS_IRQ_W-1:0] = imsk_r;
    end
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_r <= 1'b0;
        err_r <= 1'b0;
        rd_r <= 32'h0000_0000;
    end
    else
    begin
        ack_r <= ack_nxt;
        err_r <= err_nxt;
        rd_r <= rd_nxt;
    end
end

assign wb_ack_o = ack_r;
assign wb_err_o = err_r;
assign wb_dat_o = rd_r;

////////////////////////////////////////////////////////////////////////////////

status_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr0 && idx == `ACCS_IDX_STAT) |=>
    stat_r[`ACCS_STAT_RSVD_HI:`ACCS_STAT_RSVD_LO] == 3'b000 &&
    stat_r[`ACCS_BIT_DONE] == $past(s_done))
    else $error("status register took bus data");
avg_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr0 && idx == `ACCS_IDX_AVG) |=>
    offset_averaging_level_o ==
    $past(wb_dat_i[`ACCS_OSAVG_HI:`ACCS_OSAVG_LO]))
    else $error("offset averaging not taken");
lin_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr0 && idx == `ACCS_IDX_AVG) |=>
    linearity_averaging_level_o ==
    $past(wb_dat_i[`ACCS_LINAVG_HI:`ACCS_LINAVG_LO]))
    else $error("linearity averaging not taken");
ref_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr0 && idx == `ACCS_IDX_OSCFG) |=>
    offset_reference_select_o == $past(wb_dat_i[`ACCS_BIT_OFFREF]))
    else $error("offset reference not taken");
bgen_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr0 && idx == `ACCS_IDX_CALCFG0) |=>
    background_calibration_enable_o ==
    $past(wb_dat_i[`ACCS_BIT_BGEN]))
    else $error("background enable not taken");
done_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(s_done) |=> stat_r[`ACCS_BIT_DONE])
    else $error("done flag not raised");
halt_fg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cfg0_r[`ACCS_BIT_BGEN] && s_done) |=> stat_r[`ACCS_BIT_HALT])
    else $error("halt flag missing after foreground");
halt_bg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg0_r[`ACCS_BIT_BGEN] && s_run) |=> !stat_r[`ACCS_BIT_HALT])
    else $error("halt flag kept while running");
halt_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg0_r[`ACCS_BIT_BGEN] && s_halt && !s_run) |=>
    stat_r[`ACCS_BIT_HALT])
    else $error("halt flag not set");
code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_code == code_prev_r) |-> ##2
    stat_r[`ACCS_CODE_HI:`ACCS_CODE_LO] == $past(s_code, 2))
    else $error("status code mismatch");

endmodule

// ==== bench/accs_top_tb_top.sv ====
`timescale 1ns/100ps
`include "accs_cfg.svh"
module accs_top_tb_top;
import accs_pkg::*;
logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic cyc = 1'b0;
logic stb = 1'b0;
logic we = 1'b0;
logic [9:0] adr = '0;
logic [31:0] di = '0;
logic [31:0] dout;
logic ack, berr, fgd = 1'b0, hlt = 1'b0, run = 1'b0, irq;
logic oref, bgen, fgrun;
logic [3:0] sel = 4'hf;
logic [2:0] code = '0;
logic [2:0] osavg, linavg;
logic [32:0] exp_q[$];
int err_count = 0;
int n_compared = 0;
always #4 clk_i = ~clk_i;
accs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di),
    .wb_dat_o(dout), .wb_ack_o(ack), .wb_err_o(berr), .fg_complete_i(fgd),
    .bg_halted_i(hlt), .bg_running_i(run), .cal_code_i(code),
    .offset_reference_select_o(oref), .offset_averaging_level_o(osavg),
    .linearity_averaging_level_o(linavg),
    .background_calibration_enable_o(bgen), .foreground_run_o(fgrun),
    .irq_o(irq));
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    n_compared++;
    if (seen !== want)
    begin
        err_count++;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            want);
    end
endtask
task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
// Every transfer leaves a note: error flag and read data (zero on writes)
task automatic bus(input logic w, input logic [7:0] idx,
    input logic [7:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    di <= {24'h0000_00, d};
    // The wait ends on ack or err; only the watchdog ends a wait that gets neither
    do
    begin
        @(posedge clk_i);
    end
    while (ack !== 1'b1 && berr !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
endtask
task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 33'h0_0000_0000);
endtask
task automatic rd(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b0, idx, 8'h00, {25'h000_0000, v});
endtask
task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
endtask
// Answers are judged at the edge where the master sees them
always @(posedge clk_i)
begin
    if (ack === 1'b1 || berr === 1'b1)
    begin
        if (exp_q.size() == 0)
            chk(33'h1_ffff_ffff, 33'h0_0000_0000);
        else
            chk({berr, (we || berr) ? 32'h0000_0000 : dout},
                exp_q.pop_front());
    end
end
////////////////////////////////////////////////////////////////////////////////
initial
begin
    logic [7:0] d;
    logic [2:0] c;
    void'($urandom(32'hb414));
    tick(20);
    rst_i <= 1'b0;
    rd(`ACCS_IDX_OSCFG, 8'h01);
    rd(`ACCS_IDX_AVG, 8'h61);
    rd(`ACCS_IDX_CALCFG0, 8'h01);
    rd(`ACCS_IDX_STAT, 8'h00);
    chk({24'h0, oref, osavg, linavg, bgen, fgrun}, 33'h0_0000_00c5);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
        d = 8'($urandom) & 8'h77;
        wr(`ACCS_IDX_AVG, d);
        rd(`ACCS_IDX_AVG, d);
        chk({27'h0, osavg, linavg}, {27'h0, d[6:4], d[2:0]});
    end
    // A write without the low byte lane leaves the register alone
    sel <= 4'he;
    wr(`ACCS_IDX_AVG, 8'h00);
    sel <= 4'hf;
    rd(`ACCS_IDX_AVG, d);
    $display("test averaging done");
    wr(`ACCS_IDX_CALCFG0, 8'h02);
    chk({31'h0, bgen, fgrun}, 33'h0_0000_0002);
    wr(`ACCS_IDX_OSCFG, 8'h05);
    rd(`ACCS_IDX_OSCFG, 8'h05);
    chk({32'h0, oref}, 33'h1);
    wr(`ACCS_IDX_OSCFG, 8'h01);
    chk({32'h0, oref}, 33'h0);
    $display("test reference done");
    wr(`ACCS_IDX_IRQ_MASK, 8'h03);
    c = 3'($urandom);
    code <= c;
    hlt <= 1'b1;
    tick(6);
    rd(`ACCS_IDX_STAT, {3'b000, c, 2'b10});
    chk({32'h0, irq}, 33'h1);
    rd(`ACCS_IDX_IRQ_STAT, 8'h02);
    wr(`ACCS_IDX_IRQ_STAT, 8'h02);
    tick(2);
    chk({32'h0, irq}, 33'h0);
    run <= 1'b1;
    tick(6);
    rd(`ACCS_IDX_STAT, {3'b000, c, 2'b00});
    wr(`ACCS_IDX_STAT, 8'hff);
    rd(`ACCS_IDX_STAT, {3'b000, c, 2'b00});
    $display("test background status done");
    wr(`ACCS_IDX_CALCFG0, 8'h01);
    fgd <= 1'b1;
    tick(6);
    rd(`ACCS_IDX_STAT, {3'b000, c, 2'b11});
    rd(`ACCS_IDX_IRQ_STAT, 8'h03);
    chk({32'h0, irq}, 33'h1);
    wr(`ACCS_IDX_IRQ_MASK, 8'h00);
    tick(2);
    chk({32'h0, irq}, 33'h0);
    wr(`ACCS_IDX_IRQ_STAT, 8'h03);
    rd(`ACCS_IDX_IRQ_STAT, 8'h00);
    bus(1'b0, 8'h00, 8'h00, 33'h1_0000_0000);
    $display("test foreground and interrupt done");
    give_verdict();
end
initial
begin
    tick(20000);
    err_count++;
    give_verdict();
end
endmodule
